/* bench/offcore_response_event_filter_bench.sv */
// Self-checking bench for the off-core response filter
`timescale 1ns/1ps
module offcore_response_event_filter_bench
  import offcore_filter_pkg::*;
;
  logic ref_clk = 0, rst_b = 0, go = 0;
  logic [5:0] kind = '0;
  cfg_access_type cfg_access = '0;
  event_select_type [3:0] sel = '0;
  completion_type completion;
  logic [15:0] cfg_rdata, cfg_q, cfg = '0;
  logic cfg_rvalid;
  logic [3:0] offcore_match, hit;
  logic [3:0][47:0] cnt, exp_cnt = '0;
  int n_mismatch = 0, checked = 0, cycles = 0;
  always #4 ref_clk = ~ref_clk;
  offcore_response_event_filter uut (.ref_clk(ref_clk), .rst_b(rst_b), .cfg_access(cfg_access),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .core_event_select_reg(sel), .completion(completion),
    .offcore_match(offcore_match), .core_general_counter(cnt), .offcore_response_config(cfg_q));
  uncore_model far (.ref_clk(ref_clk), .rst_b(rst_b), .go(go), .kind(kind), .completion(completion));
  task close_out;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  task cmp(input string name, input logic [47:0] e, input logic [47:0] g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask : cmp
  // Reads check valid and data word; writes to 0x1a6 update the shadow copy, bit 11 dropped
  task access(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    cfg_access <= {w, !w, a, d};
    @(posedge ref_clk);
    cfg_access <= '0;
    #1;
    if (w && a == 12'h1a6)
      cfg = d & ~16'h0800;
    if (w)
      cmp("config", cfg, cfg_q);
    else
      cmp("rdata", {!w, (a == 12'h1a6) ? cfg : 16'h0000}, {cfg_rvalid, cfg_rdata});
  endtask : access
  task xact(input logic [2:0] q, input logic [2:0] r);
    @(posedge ref_clk);
    go <= 1'b1;
    kind <= {q, r};
    @(posedge ref_clk);
    go <= 1'b0;
    for (int i = 0; i < 4; i++)
      hit[i] = sel[i] == {8'hb7, 8'h01, 1'b1} && cfg[q] && cfg[8 + r] && r != 3'h3;
    @(posedge ref_clk);
    #1;
    cmp("match", hit, offcore_match);
    for (int i = 0; i < 4; i++)
    begin
      exp_cnt[i] += hit[i];
      cmp("counter", exp_cnt[i], cnt[i]);
    end
  endtask : xact
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  initial
  begin
    // Selector 1 carries a wrong event code, selector 2 a wrong mask
    sel <= {8'hb7, 8'h01, 1'b1, 8'hb7, 8'h02, 1'b1, 8'hb6, 8'h01, 1'b1, 8'hb7, 8'h01, 1'b1};
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    access(0, 12'h1a6, 16'h0000);
    access(1, 12'h1a5, 16'h1234);
    access(0, 12'h1a5, 16'h0000);
    for (int k = 0; k < 9; k++)
    begin
      access(1, 12'h1a6, (k == 8) ? 16'hffff : (16'h0101 << k));
      access(0, 12'h1a6, 16'h0000);
      for (int c = 0; c < 64; c++)
        xact(c[5:3], c[2:0]);
    end
    // All four selectors on the shared setting, then a reset in mid-run
    @(posedge ref_clk);
    sel <= {4{8'hb7, 8'h01, 1'b1}};
    access(1, 12'h1a6, 16'hffff);
    for (int c = 0; c < 64; c++)
      xact(c[5:3], c[2:0]);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    @(posedge ref_clk);
    rst_b <= 1'b1;
    cfg = '0;
    exp_cnt = '0;
    access(0, 12'h1a6, 16'h0000);
    for (int i = 0; i < 4; i++)
      cmp("counter", exp_cnt[i], cnt[i]);
    close_out();
  end
endmodule : offcore_response_event_filter_bench

/* bench/uncore_model.sv */
// Far-side model: returns one completion per requested transaction
`timescale 1ns/1ps
module uncore_model
  import offcore_filter_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic go,
  input wire logic [5:0] kind,
  output completion_type completion
);
  // Always prompt: one cycle after the request, held for as many cycles as go stays high
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      completion <= '0;
    else
      completion <= {go, kind};
  end
endmodule : uncore_model

/* hdl/offcore_filter_map.svh */
// Constants for the off-core response event filter
// Functional notes
// - Event 0xb7 mask 0x01 selects off-core counting
// - Any of four selectors may use it
// - One shared config register for all selectors
// - Bits 7:0 choose request types
// - Bits 15:8 choose response classes
// - Bit 0 counts demand and L1 data reads
// - Bit 1 counts demand ownership reads
// - Bit 2 counts demand code reads
// - Bit 3 counts writebacks
// - Bits 4-6 count L2 prefetch data/ownership/code
// - Bit 7 counts miscellaneous transactions
// - Bit 8 counts L3 hit without snoop
// - Bit 9 counts L3 hit clean snoop
// - Bit 10 counts L3 hit modified snoop
// - Bit 12 counts local cross-package forward
// - Bit 13 counts remote memory service
// - Bit 14 counts local memory service
// - Bit 15 counts I/O hub service
`ifndef OFFCORE_FILTER_MAP_SVH
`define OFFCORE_FILTER_MAP_SVH
`define OCR_CONFIG_ADDR 12'h1a6
`define OCR_EVENT_CODE 8'hb7
`define OCR_UNIT_MASK 8'h01
`define OCR_CONFIG_RESET 16'h0000
`define OCR_RESERVED_MASK 16'h0800
`define OCR_REQ_LSB 0
`define OCR_REQ_MSB 7
`define OCR_RSP_LSB 8
`define OCR_RSP_MSB 15
`define OCR_SELECTORS 4
`define OCR_COUNTER_WIDTH 48
`define OCR_BIT_DATA_READ 0
`define OCR_BIT_OWNERSHIP_READ 1
`define OCR_BIT_CODE_READ 2
`define OCR_BIT_WRITEBACK 3
`define OCR_BIT_L2_PF_DATA 4
`define OCR_BIT_L2_PF_OWNERSHIP 5
`define OCR_BIT_L2_PF_CODE 6
`define OCR_BIT_MISC 7
`define OCR_BIT_L3_HIT_NO_SNOOP 8
`define OCR_BIT_L3_HIT_CLEAN_SNOOP 9
`define OCR_BIT_L3_HIT_MODIFIED_SNOOP 10
`define OCR_BIT_RESERVED 11
`define OCR_BIT_CROSS_PACKAGE_FORWARD 12
`define OCR_BIT_REMOTE_MEMORY 13
`define OCR_BIT_LOCAL_MEMORY 14
`define OCR_BIT_IO_HUB 15
`endif

/* hdl/offcore_filter_pkg.sv */
// Types for the off-core response event filter
package offcore_filter_pkg;
  // Request kinds, one bit each in the request byte
  typedef enum logic [2:0] {
    req_data_read = 3'h0,
    req_ownership_read = 3'h1,
    req_code_read = 3'h2,
    req_writeback = 3'h3,
    req_l2_pf_data = 3'h4,
    req_l2_pf_ownership = 3'h5,
    req_l2_pf_code = 3'h6,
    req_misc = 3'h7
  } req_kind_type;
  // Response classes; code 3 is reserved and never matches
  typedef enum logic [2:0] {
    rsp_l3_hit_no_snoop = 3'h0,
    rsp_l3_hit_clean_snoop = 3'h1,
    rsp_l3_hit_modified_snoop = 3'h2,
    rsp_reserved = 3'h3,
    rsp_cross_package_forward = 3'h4,
    rsp_remote_memory = 3'h5,
    rsp_local_memory = 3'h6,
    rsp_io_hub = 3'h7
  } rsp_kind_type;
  typedef struct packed {
    logic valid;
    req_kind_type req;
    rsp_kind_type rsp;
  } completion_type;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [15:0] wdata;
  } cfg_access_type;
  typedef struct packed {
    logic [7:0] event_code;
    logic [7:0] unit_mask;
    logic enable;
  } event_select_type;
  typedef struct packed {
    logic [15:0] config_q;
    logic [15:0] rdata;
    logic rvalid;
    logic [3:0] hit;
    logic [3:0][47:0] count;
  } filter_state_type;
endpackage : offcore_filter_pkg

/* hdl/offcore_response_event_filter.sv */
// Off-core response qualifier and the four core counters it feeds
`timescale 1ns/1ps
`include "offcore_filter_map.svh"
module offcore_response_event_filter
  import offcore_filter_pkg::*;
#(
  parameter int SELECTORS = `OCR_SELECTORS,
  parameter int COUNTER_WIDTH = `OCR_COUNTER_WIDTH
)(
  input wire logic ref_clk,
  input wire logic rst_b,
  input cfg_access_type cfg_access,
  output logic [15:0] cfg_rdata,
  output logic cfg_rvalid,
  input event_select_type [3:0] core_event_select_reg,
  input completion_type completion,
  output logic [3:0] offcore_match,
  output logic [3:0][47:0] core_general_counter,
  output logic [15:0] offcore_response_config
);

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic is_offcore_event(input event_select_type sel);
    is_offcore_event = sel.enable && (sel.event_code == `OCR_EVENT_CODE)
                       && (sel.unit_mask == `OCR_UNIT_MASK);
  endfunction : is_offcore_event

  function automatic logic req_allowed(input logic [15:0] cfg, input req_kind_type req);
    logic [7:0] req_sel;
    req_sel = cfg[`OCR_REQ_MSB:`OCR_REQ_LSB];
    // Each request kind owns its bit
    req_allowed = req_sel[req];
  endfunction : req_allowed

  function automatic logic rsp_allowed(input logic [15:0] cfg, input rsp_kind_type rsp);
    logic [7:0] rsp_sel;
    rsp_sel = cfg[`OCR_RSP_MSB:`OCR_RSP_LSB];
    // Each response class owns its bit, bit 11 never counts
    rsp_allowed = rsp_sel[rsp] && (rsp != rsp_reserved);
  endfunction : rsp_allowed

  function automatic logic qualifies(input logic [15:0] cfg, input completion_type c);
    qualifies = c.valid && req_allowed(cfg, c.req) && rsp_allowed(cfg, c.rsp);
  endfunction : qualifies

  // ----------------------------------------
  // State
  // ----------------------------------------
  filter_state_type state_reg;
  filter_state_type state_next;
  logic match_now;

  always_comb
  begin
    state_next = state_reg;
    state_next.rvalid = 1'b0;
    if (cfg_access.wr && cfg_access.addr == `OCR_CONFIG_ADDR)
    begin
      // Reserved bit is not stored, so it always reads zero
      state_next.config_q = cfg_access.wdata & ~`OCR_RESERVED_MASK;
    end
    if (cfg_access.rd)
    begin
      state_next.rvalid = 1'b1;
      state_next.rdata = (cfg_access.addr == `OCR_CONFIG_ADDR) ? state_reg.config_q : 16'h0000;
    end
    match_now = qualifies(state_reg.config_q, completion);
    // One shared config qualifies every selector
    for (int i = 0; i < SELECTORS; i++)
    begin
      state_next.hit[i] = match_now && is_offcore_event(core_event_select_reg[i]);
      if (state_next.hit[i])
      begin
        state_next.count[i] = state_reg.count[i] + 48'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign cfg_rdata = state_reg.rdata;
  assign cfg_rvalid = state_reg.rvalid;
  assign offcore_match = state_reg.hit;
  assign core_general_counter = state_reg.count;
  assign offcore_response_config = state_reg.config_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  event_sel_a: assert property (offcore_match[0] |-> $past(is_offcore_event(core_event_select_reg[0])))
    else $error("Counter 0 counted without off-core event selected");
  count_step_a: assert property (offcore_match[1] |-> core_general_counter[1] == $past(core_general_counter[1]) + 48'h1)
    else $error("Counter 1 did not step by one");
  no_count_a: assert property (!offcore_match[2] |-> $stable(core_general_counter[2]))
    else $error("Counter 2 moved without a match");
  shared_cfg_a: assert property ((offcore_match[0] && is_offcore_event(core_event_select_reg[3])
                                  && $past(is_offcore_event(core_event_select_reg[3])))
                                 |-> offcore_match[3])
    else $error("Selectors disagree on shared qualification");
  req_bits_a: assert property (offcore_match[0] |-> $past(offcore_response_config[completion.req]))
    else $error("Counted a request type that is not selected");
  rsp_bits_a: assert property (offcore_match[0] |-> $past(offcore_response_config[`OCR_RSP_LSB + completion.rsp]))
    else $error("Counted a response class that is not selected");
  reserved_a: assert property (offcore_response_config[11] == 1'b0)
    else $error("Reserved bit stored");
  cfg_write_a: assert property (cfg_access.wr && cfg_access.addr == `OCR_CONFIG_ADDR
                                |=> offcore_response_config == ($past(cfg_access.wdata) & ~`OCR_RESERVED_MASK))
    else $error("Config write not stored");
  idle_a: assert property (!$past(completion.valid) |-> offcore_match == 4'h0)
    else $error("Counted without a completion");

  // ----------------------------------------
  // Register checks
  // ----------------------------------------
  rd_answer_a: assert property (cfg_access.rd |=> cfg_rvalid)
    else $error("Read answer missing");
  no_answer_a: assert property (!cfg_access.rd |=> !cfg_rvalid)
    else $error("Read answer without a read");
  rd_data_a: assert property (cfg_access.rd && cfg_access.addr == `OCR_CONFIG_ADDR
      |=> cfg_rdata == $past(offcore_response_config))
    else $error("Read data differs from the shared setting");
  rd_other_a: assert property (cfg_access.rd && cfg_access.addr != `OCR_CONFIG_ADDR |=> cfg_rdata == 16'h0000)
    else $error("Unmapped read returned data");
  rdata_hold_a: assert property (!cfg_access.rd |=> $stable(cfg_rdata))
    else $error("Read data moved without a read");
  cfg_hold_a: assert property (!(cfg_access.wr && cfg_access.addr == `OCR_CONFIG_ADDR)
      |=> $stable(offcore_response_config))
    else $error("Setting changed without a write");
  rd_reserved_a: assert property (cfg_rvalid |-> !cfg_rdata[`OCR_BIT_RESERVED])
    else $error("Reserved bit read back set");

  // ----------------------------------------
  // Request select checks
  // ----------------------------------------
  data_read_off_a: assert property ($past(completion.valid && completion.req == req_data_read
      && !offcore_response_config[`OCR_BIT_DATA_READ])
      |-> offcore_match == 4'h0)
    else $error("Deselected demand data read counted");
  data_read_on_a: assert property ($past(completion.valid && completion.req == req_data_read
      && offcore_response_config[`OCR_BIT_DATA_READ]
      && rsp_allowed(offcore_response_config, completion.rsp)
      && is_offcore_event(core_event_select_reg[0])) |-> offcore_match[0])
    else $error("Selected demand data read not counted");

  own_read_off_a: assert property ($past(completion.valid && completion.req == req_ownership_read
      && !offcore_response_config[`OCR_BIT_OWNERSHIP_READ])
      |-> offcore_match == 4'h0)
    else $error("Deselected ownership read counted");
  own_read_on_a: assert property ($past(completion.valid && completion.req == req_ownership_read
      && offcore_response_config[`OCR_BIT_OWNERSHIP_READ]
      && rsp_allowed(offcore_response_config, completion.rsp)
      && is_offcore_event(core_event_select_reg[0])) |-> offcore_match[0])
    else $error("Selected ownership read not counted");

  code_read_off_a: assert property ($past(completion.valid && completion.req == req_code_read
      && !offcore_response_config[`OCR_BIT_CODE_READ])
      |-> offcore_match == 4'h0)
    else $error("Deselected code read counted");
  code_read_on_a: assert property ($past(completion.valid && completion.req == req_code_read
      && offcore_response_config[`OCR_BIT_CODE_READ]
      && rsp_allowed(offcore_response_config, completion.rsp)
      && is_offcore_event(core_event_select_reg[0])) |-> offcore_match[0])
    else $error("Selected code read not counted");

  writeback_off_a: assert property ($past(completion.valid && completion.req == req_writeback
      && !offcore_response_config[`OCR_BIT_WRITEBACK])
      |-> offcore_match == 4'h0)
    else $error("Deselected writeback counted");
  writeback_on_a: assert property ($past(completion.valid && completion.req == req_writeback
      && offcore_response_config[`OCR_BIT_WRITEBACK]
      && rsp_allowed(offcore_response_config, completion.rsp)
      && is_offcore_event(core_event_select_reg[0])) |-> offcore_match[0])
    else $error("Selected writeback not counted");

  pf_data_off_a: assert property ($past(completion.valid && completion.req == req_l2_pf_data
      && !offcore_response_config[`OCR_BIT_L2_PF_DATA])
      |-> offcore_match == 4'h0)
    else $error("Deselected prefetch data read counted");
  pf_data_on_a: assert property ($past(completion.valid && completion.req == req_l2_pf_data
      && offcore_response_config[`OCR_BIT_L2_PF_DATA]
      && rsp_allowed(offcore_response_config, completion.rsp)
      && is_offcore_event(core_event_select_reg[0])) |-> offcore_match[0])
    else $error("Selected prefetch data read not counted");

  pf_own_off_a: assert property ($past(completion.valid && completion.req == req_l2_pf_ownership
      && !offcore_response_config[`OCR_BIT_L2_PF_OWNERSHIP])
      |-> offcore_match == 4'h0)
    else $error("Deselected prefetch ownership read counted");
  pf_own_on_a: assert property ($past(completion.valid && completion.req == req_l2_pf_ownership
      && offcore_response_config[`OCR_BIT_L2_PF_OWNERSHIP]
      && rsp_allowed(offcore_response_config, completion.rsp)
      && is_offcore_event(core_event_select_reg[0])) |-> offcore_match[0])
    else $error("Selected prefetch ownership read not counted");

  pf_code_off_a: assert property ($past(completion.valid && completion.req == req_l2_pf_code
      && !offcore_response_config[`OCR_BIT_L2_PF_CODE])
      |-> offcore_match == 4'h0)
    else $error("Deselected prefetch code read counted");
  pf_code_on_a: assert property ($past(completion.valid && completion.req == req_l2_pf_code
      && offcore_response_config[`OCR_BIT_L2_PF_CODE]
      && rsp_allowed(offcore_response_config, completion.rsp)
      && is_offcore_event(core_event_select_reg[0])) |-> offcore_match[0])
    else $error("Selected prefetch code read not counted");

  misc_off_a: assert property ($past(completion.valid && completion.req == req_misc
      && !offcore_response_config[`OCR_BIT_MISC])
      |-> offcore_match == 4'h0)
    else $error("Deselected miscellaneous transaction counted");
  misc_on_a: assert property ($past(completion.valid && completion.req == req_misc
      && offcore_response_config[`OCR_BIT_MISC]
      && rsp_allowed(offcore_response_config, completion.rsp)
      && is_offcore_event(core_event_select_reg[0])) |-> offcore_match[0])
    else $error("Selected miscellaneous transaction not counted");

  // ----------------------------------------
  // Response select checks
  // ----------------------------------------
  no_snoop_off_a: assert property ($past(completion.valid && completion.rsp == rsp_l3_hit_no_snoop
      && !offcore_response_config[`OCR_BIT_L3_HIT_NO_SNOOP])
      |-> offcore_match == 4'h0)
    else $error("Deselected plain hit counted");
  no_snoop_on_a: assert property ($past(completion.valid && completion.rsp == rsp_l3_hit_no_snoop
      && offcore_response_config[`OCR_BIT_L3_HIT_NO_SNOOP]
      && req_allowed(offcore_response_config, completion.req)
      && is_offcore_event(core_event_select_reg[0])) |-> offcore_match[0])
    else $error("Selected plain hit not counted");

  clean_snoop_off_a: assert property ($past(completion.valid && completion.rsp == rsp_l3_hit_clean_snoop
      && !offcore_response_config[`OCR_BIT_L3_HIT_CLEAN_SNOOP])
      |-> offcore_match == 4'h0)
    else $error("Deselected clean snoop hit counted");
  clean_snoop_on_a: assert property ($past(completion.valid && completion.rsp == rsp_l3_hit_clean_snoop
      && offcore_response_config[`OCR_BIT_L3_HIT_CLEAN_SNOOP]
      && req_allowed(offcore_response_config, completion.req)
      && is_offcore_event(core_event_select_reg[0])) |-> offcore_match[0])
    else $error("Selected clean snoop hit not counted");

  mod_snoop_off_a: assert property ($past(completion.valid && completion.rsp == rsp_l3_hit_modified_snoop
      && !offcore_response_config[`OCR_BIT_L3_HIT_MODIFIED_SNOOP])
      |-> offcore_match == 4'h0)
    else $error("Deselected modified snoop hit counted");
  mod_snoop_on_a: assert property ($past(completion.valid && completion.rsp == rsp_l3_hit_modified_snoop
      && offcore_response_config[`OCR_BIT_L3_HIT_MODIFIED_SNOOP]
      && req_allowed(offcore_response_config, completion.req)
      && is_offcore_event(core_event_select_reg[0])) |-> offcore_match[0])
    else $error("Selected modified snoop hit not counted");

  forward_off_a: assert property ($past(completion.valid && completion.rsp == rsp_cross_package_forward
      && !offcore_response_config[`OCR_BIT_CROSS_PACKAGE_FORWARD])
      |-> offcore_match == 4'h0)
    else $error("Deselected forwarded miss counted");
  forward_on_a: assert property ($past(completion.valid && completion.rsp == rsp_cross_package_forward
      && offcore_response_config[`OCR_BIT_CROSS_PACKAGE_FORWARD]
      && req_allowed(offcore_response_config, completion.req)
      && is_offcore_event(core_event_select_reg[0])) |-> offcore_match[0])
    else $error("Selected forwarded miss not counted");

  remote_off_a: assert property ($past(completion.valid && completion.rsp == rsp_remote_memory
      && !offcore_response_config[`OCR_BIT_REMOTE_MEMORY])
      |-> offcore_match == 4'h0)
    else $error("Deselected remote memory miss counted");
  remote_on_a: assert property ($past(completion.valid && completion.rsp == rsp_remote_memory
      && offcore_response_config[`OCR_BIT_REMOTE_MEMORY]
      && req_allowed(offcore_response_config, completion.req)
      && is_offcore_event(core_event_select_reg[0])) |-> offcore_match[0])
    else $error("Selected remote memory miss not counted");

  local_off_a: assert property ($past(completion.valid && completion.rsp == rsp_local_memory
      && !offcore_response_config[`OCR_BIT_LOCAL_MEMORY])
      |-> offcore_match == 4'h0)
    else $error("Deselected local memory miss counted");
  local_on_a: assert property ($past(completion.valid && completion.rsp == rsp_local_memory
      && offcore_response_config[`OCR_BIT_LOCAL_MEMORY]
      && req_allowed(offcore_response_config, completion.req)
      && is_offcore_event(core_event_select_reg[0])) |-> offcore_match[0])
    else $error("Selected local memory miss not counted");

  io_hub_off_a: assert property ($past(completion.valid && completion.rsp == rsp_io_hub
      && !offcore_response_config[`OCR_BIT_IO_HUB])
      |-> offcore_match == 4'h0)
    else $error("Deselected hub request counted");
  io_hub_on_a: assert property ($past(completion.valid && completion.rsp == rsp_io_hub
      && offcore_response_config[`OCR_BIT_IO_HUB]
      && req_allowed(offcore_response_config, completion.req)
      && is_offcore_event(core_event_select_reg[0])) |-> offcore_match[0])
    else $error("Selected hub request not counted");

  // Reserved class must stay silent even with every bit set, since bit 11 is never stored
  reserved_rsp_a: assert property ($past(completion.valid && completion.rsp == rsp_reserved) |-> offcore_match == 4'h0)
    else $error("Reserved response class counted");

  // ----------------------------------------
  // Per-selector checks
  // ----------------------------------------
  for (genvar g = 0; g < SELECTORS; g++)
  begin : per_selector
    gate_a: assert property (offcore_match[g] |-> $past(is_offcore_event(core_event_select_reg[g])))
      else $error("Counted without the off-core event selected");
    disabled_a: assert property ($past(!core_event_select_reg[g].enable) |-> !offcore_match[g])
      else $error("Counted while the selector is disabled");
    step_a: assert property (offcore_match[g]
        |-> core_general_counter[g] == $past(core_general_counter[g]) + 48'h1)
      else $error("Counter did not step by one");
    hold_a: assert property (!offcore_match[g] |-> $stable(core_general_counter[g]))
      else $error("Counter moved without a match");
    same_cfg_a: assert property (offcore_match[0] && $past(is_offcore_event(core_event_select_reg[g]))
        |-> offcore_match[g])
      else $error("Selectors disagree on the shared setting");
  end

  writeback_cov: cover property (offcore_match[0] && $past(completion.req) == req_writeback);
  io_hub_cov: cover property (offcore_match[1] && $past(completion.rsp) == rsp_io_hub);
  all_four_cov: cover property (offcore_match == 4'hf);
  reserved_rsp_cov: cover property (completion.valid && completion.rsp == rsp_reserved);
  cfg_read_cov: cover property (cfg_rvalid && cfg_rdata != 16'h0000);
endmodule : offcore_response_event_filter
